// ==== design/rlem_cfg.svh ====
// Constants of the radio link error monitor.
`ifndef RLEM_CFG_SVH
`define RLEM_CFG_SVH
`define RLEM_CLK_HZ      10000000
`define RLEM_SEC_S       1
`define RLEM_SEC_CYCLES  (`RLEM_CLK_HZ * `RLEM_SEC_S)
`define RLEM_PPM         1000000
`define RLEM_THR_MINOR   32'h0000_00c8
`define RLEM_THR_MAJOR   32'h0000_4e20
`define RLEM_THR_FAULT   32'h001e_8480
`define RLEM_THR_ESR     32'h0000_9c40
`define RLEM_THR_SESR    32'h0000_07d0
`define RLEM_THR_BBER    32'h0000_f424
`define RLEM_THR_SES     32'h0004_93e0
`define RLEM_NTHR        6
`define RLEM_NCMP        7
`define RLEM_I_MINOR     0
`define RLEM_I_MAJOR     1
`define RLEM_I_FAULT     2
`define RLEM_I_ESR       3
`define RLEM_I_SESR      4
`define RLEM_I_BBER      5
`define RLEM_I_SES       6
`define RLEM_RECOV_S     3'h5
`define RLEM_AVAIL_RUN   4'ha
`define RLEM_PWR_MIN     5'h02
`define RLEM_PWR_MAX     5'h18
`define RLEM_PWR_RST     5'h02
`define RLEM_AIS         8'hff
`endif

// ==== design/rlem_cmp_if.sv ====
// Ratio comparison request between the monitor and a comparator.
`timescale 1ns/1ns
interface rlem_cmp_if #(parameter int W = 32);
    logic [W-1:0] num;
    logic [W-1:0] den;
    logic [31:0]  thr;
    logic         over;
    modport cmp  (input num, input den, input thr, output over);
    modport user (output num, output den, output thr, input over);
endinterface : rlem_cmp_if

// ==== design/rlem_monitor.sv ====
// Radio link supervision: loopbacks, outdoor unit settings and error monitoring.
// Summary of operation
// - With timeout enabled, loopback ends after configured seconds.
// - With timeout disabled, only a management clear or a new apply ends loopback.
// - Baseband loopback returns user payload at the outdoor baseband stage.
// - RF loopback turns all local data around at the outdoor output stage.
// - Outdoor settings are held here and programmed after every reset.
// - Transmit power is limited to 2..24 dBm, with a separate mute.
// - Channel plan selects one of plans A, B, C or D.
// - Autorecovery restores default RF settings if no contact within 5 seconds.
// - Falling back to default settings raises a status flag.
// - While frame lock is lost, AIS replaces payload toward the line.
// - With monitoring on, rate above fault threshold raises the fault status.
// - Per-second rate is uncorrectable blocks over blocks in that second.
// - Minor, major and fault thresholds default 0.0002, 0.02 and 2.0.
// - ES, SES and BBE ratios checked each second against their thresholds.
// - Ten consecutive severe seconds start unavailable time, counted unavailable.
// - Ten consecutive non-severe seconds start available time, counted available.
// - A second with over 30% errored blocks is severely errored and counted.
// - Each second with any errored block increments the errored seconds count.
// - Background errors exclude blocks of severely errored seconds.
// - Total seconds since clear are kept as the ES and SES ratio denominator.
// - The highest rate since the last clear is kept as a peak.
// - Rate above minor or major threshold raises the front panel error output.
`timescale 1ns/1ns
`include "rlem_cfg.svh"
module rlem_monitor
    import rlem_pkg::*;
#(
    parameter int CW         = 32,
    parameter int SEC_CYCLES = `RLEM_SEC_CYCLES
)(
    // Clock and reset
    input  wire logic          clk_i,
    input  wire logic          srst_i,
    // Loopback control from the management station
    input  wire logic          lb_apply_i,
    input  wire rlem_lb_t      lb_mode_i,
    input  wire logic          lb_clear_i,
    input  wire logic          lb_to_en_i,
    input  wire logic [7:0]    lb_to_sec_i,
    // Outdoor unit settings
    input  wire logic          cfg_apply_i,
    input  wire logic [4:0]    cfg_pwr_i,
    input  wire logic          cfg_mute_i,
    input  wire rlem_plan_t    cfg_plan_i,
    input  wire logic          autorec_en_i,
    // Thresholds, monitoring and clear
    input  wire logic          thr_wr_i,
    input  wire logic [2:0]    thr_sel_i,
    input  wire logic [31:0]   thr_val_i,
    input  wire logic          mon_en_i,
    input  wire logic          clr_i,
    // Link side
    input  wire logic          remote_ok_i,
    input  wire logic          frame_unlock_i,
    input  wire logic          blk_i,
    input  wire logic          blk_err_i,
    input  wire logic [7:0]    payload_i,
    // Outdoor unit control
    output logic               lb_bb_o,
    output logic               lb_rf_o,
    output logic               odu_prog_o,
    output logic [4:0]         odu_pwr_o,
    output logic               odu_mute_o,
    output rlem_plan_t         odu_plan_o,
    output logic               dflt_act_o,
    output logic [7:0]         payload_o,
    // Alarms
    output logic               per_minor_o,
    output logic               per_major_o,
    output logic               per_fault_o,
    output logic               rf_err_led_o,
    output logic               esr_exc_o,
    output logic               sesr_exc_o,
    output logic               bber_exc_o,
    output logic               link_unavail_o,
    // Counters
    output logic [CW-1:0]      eb_cnt_o,
    output logic [CW-1:0]      es_cnt_o,
    output logic [CW-1:0]      ses_cnt_o,
    output logic [CW-1:0]      bbe_cnt_o,
    output logic [CW-1:0]      tot_sec_o,
    output logic [CW-1:0]      avail_sec_o,
    output logic [CW-1:0]      unavail_sec_o,
    output logic [CW-1:0]      per_err_o,
    output logic [CW-1:0]      per_blk_o,
    output logic [CW-1:0]      peak_err_o,
    output logic [CW-1:0]      peak_blk_o
);
    function automatic logic [31:0] thr_default(input int i);
        case (i)
            `RLEM_I_MINOR: thr_default = `RLEM_THR_MINOR;
            `RLEM_I_MAJOR: thr_default = `RLEM_THR_MAJOR;
            `RLEM_I_FAULT: thr_default = `RLEM_THR_FAULT;
            `RLEM_I_ESR:   thr_default = `RLEM_THR_ESR;
            `RLEM_I_SESR:  thr_default = `RLEM_THR_SESR;
            default:       thr_default = `RLEM_THR_BBER;
        endcase
    endfunction : thr_default

    // Seconds divider and frame unlock synchroniser.
    logic [31:0]  div;
    logic         tick;
    logic         fu_m;
    logic         fu_s;
    assign tick = (div == 32'(SEC_CYCLES - 1));
    always_ff @(posedge clk_i) begin
        fu_m <= frame_unlock_i;
        fu_s <= fu_m;
        if (srst_i || tick) begin
            div <= 32'h0;
        end else begin
            div <= div + 32'h1;
        end
    end

    // Payload toward the line carries AIS while frame lock is lost.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            payload_o <= 8'h0;
        end else begin
            payload_o <= fu_s ? `RLEM_AIS : payload_i;
        end
    end

    // Loopback control.
    logic        next_bb;
    logic        next_rf;
    logic [7:0]  lb_sec;
    logic [7:0]  next_lb_sec;
    always_comb begin
        next_bb     = lb_bb_o;
        next_rf     = lb_rf_o;
        next_lb_sec = lb_sec;
        if (lb_apply_i) begin
            next_bb     = (lb_mode_i == RLEM_LB_BB);
            next_rf     = (lb_mode_i == RLEM_LB_RF);
            next_lb_sec = 8'h0;
        end else if (lb_clear_i) begin
            next_bb = 1'b0;
            next_rf = 1'b0;
        end else if (tick && (lb_bb_o || lb_rf_o) && lb_to_en_i) begin
            if (9'(lb_sec) + 9'h1 >= 9'(lb_to_sec_i)) begin
                next_bb = 1'b0;
                next_rf = 1'b0;
            end else begin
                next_lb_sec = lb_sec + 8'h1;
            end
        end
    end
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            lb_bb_o <= 1'b0;
            lb_rf_o <= 1'b0;
            lb_sec  <= 8'h0;
        end else begin
            lb_bb_o <= next_bb;
            lb_rf_o <= next_rf;
            lb_sec  <= next_lb_sec;
        end
    end

    // Outdoor settings, programming and autorecovery.
    rlem_state_t state;
    rlem_state_t next_state;
    logic [4:0]  dflt_pwr;
    logic [4:0]  next_dflt_pwr;
    logic        dflt_mute;
    logic        next_dflt_mute;
    rlem_plan_t  dflt_plan;
    rlem_plan_t  next_dflt_plan;
    logic [4:0]  next_pwr;
    logic        next_mute;
    rlem_plan_t  next_plan;
    logic        next_prog;
    logic        next_dflt_act;
    logic [2:0]  rec_sec;
    logic [2:0]  next_rec_sec;
    logic [4:0]  pwr_lim;
    assign pwr_lim = (cfg_pwr_i < `RLEM_PWR_MIN) ? `RLEM_PWR_MIN :
                     (cfg_pwr_i > `RLEM_PWR_MAX) ? `RLEM_PWR_MAX : cfg_pwr_i;
    always_comb begin
        next_state     = state;
        next_dflt_pwr  = dflt_pwr;
        next_dflt_mute = dflt_mute;
        next_dflt_plan = dflt_plan;
        next_pwr       = odu_pwr_o;
        next_mute      = odu_mute_o;
        next_plan      = odu_plan_o;
        next_prog      = 1'b0;
        next_dflt_act  = dflt_act_o;
        next_rec_sec   = rec_sec;
        case (state)
            RLEM_ST_BOOT: begin
                next_prog  = 1'b1;
                next_state = RLEM_ST_RUN;
            end
            RLEM_ST_RUN, RLEM_ST_WAIT: begin
                if (cfg_apply_i) begin
                    next_pwr      = pwr_lim;
                    next_mute     = cfg_mute_i;
                    next_plan     = cfg_plan_i;
                    next_prog     = 1'b1;
                    next_dflt_act = 1'b0;
                    next_rec_sec  = 3'h0;
                    next_state    = autorec_en_i ? RLEM_ST_WAIT : RLEM_ST_RUN;
                    if (state == RLEM_ST_RUN) begin
                        next_dflt_pwr  = odu_pwr_o;
                        next_dflt_mute = odu_mute_o;
                        next_dflt_plan = odu_plan_o;
                    end
                end else if (state == RLEM_ST_WAIT) begin
                    if (remote_ok_i) begin
                        next_state = RLEM_ST_RUN;
                    end else if (tick) begin
                        next_rec_sec = rec_sec + 3'h1;
                        if (rec_sec == `RLEM_RECOV_S - 3'h1) begin
                            next_pwr      = dflt_pwr;
                            next_mute     = dflt_mute;
                            next_plan     = dflt_plan;
                            next_prog     = 1'b1;
                            next_dflt_act = 1'b1;
                            next_state    = RLEM_ST_RUN;
                        end
                    end
                end
            end
            default: next_state = RLEM_ST_BOOT;
        endcase
    end
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state      <= RLEM_ST_BOOT;
            dflt_pwr   <= `RLEM_PWR_RST;
            dflt_mute  <= 1'b0;
            dflt_plan  <= RLEM_PLAN_A;
            odu_pwr_o  <= `RLEM_PWR_RST;
            odu_mute_o <= 1'b0;
            odu_plan_o <= RLEM_PLAN_A;
            odu_prog_o <= 1'b0;
            dflt_act_o <= 1'b0;
            rec_sec    <= 3'h0;
        end else begin
            state      <= next_state;
            dflt_pwr   <= next_dflt_pwr;
            dflt_mute  <= next_dflt_mute;
            dflt_plan  <= next_dflt_plan;
            odu_pwr_o  <= next_pwr;
            odu_mute_o <= next_mute;
            odu_plan_o <= next_plan;
            odu_prog_o <= next_prog;
            dflt_act_o <= next_dflt_act;
            rec_sec    <= next_rec_sec;
        end
    end

    // Thresholds and ratio comparators.
    logic [31:0]   thr [`RLEM_NTHR];
    logic [CW-1:0] sec_blk;
    logic [CW-1:0] sec_err;
    logic [CW-1:0] blk_tot;
    logic [CW-1:0] cnum [`RLEM_NCMP];
    logic [CW-1:0] cden [`RLEM_NCMP];
    logic [31:0]   cthr [`RLEM_NCMP];
    logic [`RLEM_NCMP-1:0] over;
    always_comb begin
        for (int i = 0; i < `RLEM_NCMP; i++) begin
            cnum[i] = sec_err;
            cden[i] = sec_blk;
            cthr[i] = `RLEM_THR_SES;
        end
        for (int i = 0; i < `RLEM_NTHR; i++) begin
            cthr[i] = thr[i];
        end
        cnum[`RLEM_I_ESR]  = es_cnt_o;
        cden[`RLEM_I_ESR]  = tot_sec_o;
        cnum[`RLEM_I_SESR] = ses_cnt_o;
        cden[`RLEM_I_SESR] = tot_sec_o;
        cnum[`RLEM_I_BBER] = bbe_cnt_o;
        cden[`RLEM_I_BBER] = blk_tot;
    end
    for (genvar g = 0; g < `RLEM_NCMP; g++) begin : g_cmp
        rlem_cmp_if #(.W(CW)) cif ();
        assign cif.num = cnum[g];
        assign cif.den = cden[g];
        assign cif.thr = cthr[g];
        assign over[g] = cif.over;
        rlem_ratio_cmp u_cmp (.c(cif.cmp));
    end
    for (genvar g = 0; g < `RLEM_NTHR; g++) begin : g_thr
        always_ff @(posedge clk_i) begin
            if (srst_i) begin
                thr[g] <= thr_default(g);
            end else if (thr_wr_i && (thr_sel_i == 3'(g))) begin
                thr[g] <= thr_val_i;
            end
        end
    end

    // Per-second tallies, G.826 counters and availability.
    logic          ses;
    logic          avail_run;
    logic [3:0]    run;
    logic [3:0]    next_run;
    logic          next_unavail;
    logic [CW-1:0] n_sblk, n_serr, n_btot, n_eb, n_es, n_ses, n_bbe, n_tot;
    logic [CW-1:0] n_av, n_un, n_perr, n_pblk, n_kerr, n_kblk;
    logic [7:0]    n_al;
    logic          peak_up;
    assign ses       = over[`RLEM_I_SES];
    assign avail_run = (run == `RLEM_AVAIL_RUN - 4'h1);
    assign peak_up   = (64'(sec_err) * 64'(peak_blk_o)) > (64'(peak_err_o) * 64'(sec_blk));
    always_comb begin
        n_sblk = tick ? CW'(0) : sec_blk;
        n_serr = tick ? CW'(0) : sec_err;
        n_sblk = n_sblk + CW'(blk_i);
        n_serr = n_serr + CW'(blk_i && blk_err_i);
        n_btot = blk_tot + CW'(blk_i);
        n_eb = eb_cnt_o + CW'(blk_i && blk_err_i);
        n_es = es_cnt_o;
        n_ses = ses_cnt_o;
        n_bbe = bbe_cnt_o;
        n_tot = tot_sec_o;
        n_av = avail_sec_o;
        n_un = unavail_sec_o;
        n_perr = per_err_o;
        n_pblk = per_blk_o;
        n_kerr = peak_err_o;
        n_kblk = peak_blk_o;
        n_al = {per_minor_o, per_major_o, per_fault_o, rf_err_led_o,
                esr_exc_o, sesr_exc_o, bber_exc_o, 1'b0};
        next_run = run;
        next_unavail = link_unavail_o;
        if (tick) begin
            n_perr = sec_err;
            n_pblk = sec_blk;
            n_tot = tot_sec_o + CW'(1);
            n_es = es_cnt_o + CW'(sec_err != CW'(0));
            n_ses = ses_cnt_o + CW'(ses);
            n_bbe = ses ? bbe_cnt_o : bbe_cnt_o + sec_err;
            if (peak_up || peak_blk_o == CW'(0)) begin
                n_kerr = sec_err;
                n_kblk = sec_blk;
            end
            n_al = {over[`RLEM_I_MINOR], over[`RLEM_I_MAJOR],
                    mon_en_i && over[`RLEM_I_FAULT],
                    over[`RLEM_I_MINOR] || over[`RLEM_I_MAJOR],
                    over[`RLEM_I_ESR], over[`RLEM_I_SESR], over[`RLEM_I_BBER], 1'b0};
            // Seconds are booked to the current state, then the run that
            // flipped it is moved across, so no second is counted twice.
            if (ses != link_unavail_o) begin
                next_run = run + 4'h1;
                if (avail_run) begin
                    next_unavail = ses;
                    next_run = 4'h0;
                end
            end else begin
                next_run = 4'h0;
            end
            if (next_unavail) begin
                n_un = unavail_sec_o + CW'(1);
                if (!link_unavail_o) begin
                    n_un = unavail_sec_o + CW'(`RLEM_AVAIL_RUN);
                    n_av = (avail_sec_o > CW'(run)) ? avail_sec_o - CW'(run) : CW'(0);
                end
            end else begin
                n_av = avail_sec_o + CW'(1);
                if (link_unavail_o) begin
                    n_av = avail_sec_o + CW'(`RLEM_AVAIL_RUN);
                    n_un = (unavail_sec_o > CW'(run)) ? unavail_sec_o - CW'(run) : CW'(0);
                end
            end
        end
        if (clr_i) begin
            {n_btot, n_eb, n_es, n_ses, n_bbe, n_tot} = '0;
            {n_av, n_un, n_kerr, n_kblk} = '0;
        end
    end
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            {sec_blk, sec_err, blk_tot, eb_cnt_o, es_cnt_o, ses_cnt_o} <= '0;
            {bbe_cnt_o, tot_sec_o, avail_sec_o, unavail_sec_o} <= '0;
            {per_err_o, per_blk_o, peak_err_o, peak_blk_o} <= '0;
            {per_minor_o, per_major_o, per_fault_o, rf_err_led_o} <= 4'h0;
            {esr_exc_o, sesr_exc_o, bber_exc_o} <= 3'h0;
            link_unavail_o <= 1'b0;
            run <= 4'h0;
        end else begin
            {sec_blk, sec_err, blk_tot, eb_cnt_o, es_cnt_o, ses_cnt_o} <=
                {n_sblk, n_serr, n_btot, n_eb, n_es, n_ses};
            {bbe_cnt_o, tot_sec_o, avail_sec_o, unavail_sec_o} <= {n_bbe, n_tot, n_av, n_un};
            {per_err_o, per_blk_o, peak_err_o, peak_blk_o} <= {n_perr, n_pblk, n_kerr, n_kblk};
            {per_minor_o, per_major_o, per_fault_o, rf_err_led_o} <= n_al[7:4];
            {esr_exc_o, sesr_exc_o, bber_exc_o} <= n_al[3:1];
            link_unavail_o <= next_unavail;
            run <= next_run;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    sequence s_lb_expire;
        tick && lb_to_en_i && (lb_bb_o || lb_rf_o) && !lb_apply_i && !lb_clear_i
            && (9'(lb_sec) + 9'h1 >= 9'(lb_to_sec_i));
    endsequence
    property p_lb_timeout;
        s_lb_expire |=> !lb_bb_o && !lb_rf_o;
    endproperty
    a_lb_timeout: assert property (p_lb_timeout) else $error("loopback kept");
    property p_lb_hold;
        (lb_bb_o || lb_rf_o) && !lb_to_en_i && !lb_apply_i && !lb_clear_i
            |=> $stable({lb_bb_o, lb_rf_o});
    endproperty
    a_lb_hold: assert property (p_lb_hold) else $error("loopback lost");
    property p_ais;
        fu_s |=> payload_o == `RLEM_AIS;
    endproperty
    a_ais: assert property (p_ais) else $error("no ais");
    property p_pwr;
        odu_pwr_o >= `RLEM_PWR_MIN && odu_pwr_o <= `RLEM_PWR_MAX;
    endproperty
    a_pwr: assert property (p_pwr) else $error("power out of range");
    property p_boot;
        $fell(srst_i) |-> ##[0:2] odu_prog_o;
    endproperty
    a_boot: assert property (p_boot) else $error("no boot program");
    property p_recov;
        state == RLEM_ST_WAIT && !cfg_apply_i && !remote_ok_i && tick
            && rec_sec == `RLEM_RECOV_S - 3'h1 |=> odu_prog_o && dflt_act_o
            && odu_pwr_o == $past(dflt_pwr);
    endproperty
    a_recov: assert property (p_recov) else $error("no recovery");
    property p_es;
        tick && !clr_i && sec_err != CW'(0) |=> es_cnt_o == $past(es_cnt_o) + CW'(1);
    endproperty
    a_es: assert property (p_es) else $error("errored second missed");
    property p_ses;
        tick && !clr_i && ses |=> ses_cnt_o == $past(ses_cnt_o) + CW'(1)
            && bbe_cnt_o == $past(bbe_cnt_o);
    endproperty
    a_ses: assert property (p_ses) else $error("severe second wrong");
    property p_clr;
        clr_i |=> tot_sec_o == CW'(0) && es_cnt_o == CW'(0) && peak_err_o == CW'(0)
            && avail_sec_o == CW'(0);
    endproperty
    a_clr: assert property (p_clr) else $error("clear incomplete");
    property p_tally;
        tick |=> sec_blk <= CW'(1);
    endproperty
    a_tally: assert property (p_tally) else $error("tally not restarted");
endmodule : rlem_monitor

// ==== design/rlem_pkg.sv ====
// Types shared by the radio link error monitor.
package rlem_pkg;
    typedef enum logic [1:0] {
        RLEM_PLAN_A = 2'h0,
        RLEM_PLAN_B = 2'h1,
        RLEM_PLAN_C = 2'h2,
        RLEM_PLAN_D = 2'h3
    } rlem_plan_t;
    typedef enum logic [1:0] {
        RLEM_LB_NONE = 2'h0,
        RLEM_LB_BB   = 2'h1,
        RLEM_LB_RF   = 2'h2
    } rlem_lb_t;
    typedef enum logic [2:0] {
        RLEM_ST_BOOT = 3'h1,
        RLEM_ST_RUN  = 3'h2,
        RLEM_ST_WAIT = 3'h4
    } rlem_state_t;
endpackage : rlem_pkg

// ==== design/rlem_ratio_cmp.sv ====
// Compares num/den against a threshold given in parts per million.
`timescale 1ns/1ns
`include "rlem_cfg.svh"
module rlem_ratio_cmp
    import rlem_pkg::*;
(
    rlem_cmp_if.cmp c
);
    // Cross multiplication avoids a divider; W must not exceed 32 bits.
    assign c.over = (64'(c.num) * 64'(`RLEM_PPM)) > (64'(c.thr) * 64'(c.den));
endmodule : rlem_ratio_cmp

// ==== testbench/rlem_odu_model.sv ====
// Outdoor radio unit model: keeps only what it is programmed with and sends blocks.
`timescale 1ns/1ns
module rlem_odu_model
    import rlem_pkg::*;
(
    // Clock and programming from the indoor unit
    input  wire logic       clk_i,
    input  wire logic       odu_prog_i,
    input  wire logic [4:0] odu_pwr_i,
    input  wire rlem_plan_t odu_plan_i,
    // Received blocks toward the indoor unit
    output logic            blk_o,
    output logic            blk_err_o
);
    logic [4:0] pwr = 5'h1f;
    rlem_plan_t plan;
    int         prog_cnt = 0;
    // Blocks idle low until a scenario sends them; an unknown would poison every tally.
    initial begin
        blk_o = 1'b0;
        blk_err_o = 1'b0;
    end
    // Nothing survives power-up here, so settings exist only once programmed.
    always @(posedge clk_i) begin
        if (odu_prog_i) begin
            pwr <= odu_pwr_i;
            plan <= odu_plan_i;
            prog_cnt <= prog_cnt + 1;
        end
    end
    task automatic send(input int n, input int e);
        for (int i = 0; i <= n; i++) begin
            @(posedge clk_i);
            #5;
            blk_o = (i < n);
            blk_err_o = (i < e);
        end
    endtask : send
endmodule : rlem_odu_model

// ==== testbench/tb_top.sv ====
// Self-checking bench of the radio link error monitor.
`timescale 1ns/1ns
module tb_top;
    import rlem_pkg::*;
    logic        clk_i = 1'b0;
    logic        srst_i = 1'b1;
    logic        lb_apply_i, lb_clear_i, lb_to_en_i, cfg_apply_i, cfg_mute_i, autorec_en_i;
    logic        thr_wr_i, mon_en_i, clr_i, remote_ok_i, frame_unlock_i, blk_i, blk_err_i;
    logic [7:0]  lb_to_sec_i, payload_i, payload_o;
    logic [4:0]  cfg_pwr_i, odu_pwr_o;
    logic [2:0]  thr_sel_i;
    logic [31:0] thr_val_i;
    rlem_lb_t    lb_mode_i;
    rlem_plan_t  cfg_plan_i, odu_plan_o;
    logic        lb_bb_o, lb_rf_o, odu_prog_o, odu_mute_o, dflt_act_o, per_minor_o, per_major_o;
    logic        per_fault_o, rf_err_led_o, esr_exc_o, sesr_exc_o, bber_exc_o, link_unavail_o;
    logic [31:0] eb_cnt_o, es_cnt_o, ses_cnt_o, bbe_cnt_o, tot_sec_o, avail_sec_o, unavail_sec_o;
    logic [31:0] per_err_o, per_blk_o, peak_err_o, peak_blk_o;
    int          err_total = 0;
    int          checked = 0;
    rlem_monitor #(.SEC_CYCLES(20)) i_rlem_monitor (.*);
    rlem_odu_model i_rlem_odu_model (.clk_i(clk_i), .odu_prog_i(odu_prog_o),
        .odu_pwr_i(odu_pwr_o), .odu_plan_i(odu_plan_o), .blk_o(blk_i), .blk_err_o(blk_err_i));
    always #50 clk_i = ~clk_i;
    task automatic cyc(input int n);
        repeat (n) begin
            @(posedge clk_i);
            #5;
        end
    endtask : cyc
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %0h, seen %0h", name, exp, got);
        end
    endtask : chk
    task automatic print_verdict;
        $display("checks %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : print_verdict
    // The second tick is internal, so the move of the total seconds count marks it.
    task automatic sec(input int n);
        logic [31:0] t;
        int k;
        repeat (n) begin
            t = tot_sec_o;
            k = 0;
            while (tot_sec_o === t) begin
                cyc(1);
                k++;
                if (k > 40) begin
                    chk("tick", 1, 0);
                    print_verdict();
                end
            end
        end
    endtask : sec
    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
    endtask : pulse
    task automatic t_cfg;
        logic [4:0] e;
        for (int p = 0; p < 4; p++) begin
            e = (p == 0) ? 5'h02 : (p == 3) ? 5'h18 : 5'(p * 10);
            cfg_pwr_i = 5'(p * 10);
            cfg_plan_i = rlem_plan_t'(p);
            cfg_mute_i = p[0];
            pulse(cfg_apply_i);
            chk("prog", 1, odu_prog_o);
            chk("mute", 32'(p[0]), 32'(odu_mute_o));
            chk("plan", p, 32'(odu_plan_o));
            cyc(1);
            chk("odu pwr", 32'(e), 32'(i_rlem_odu_model.pwr));
        end
    endtask : t_cfg
    task automatic t_auto;
        cfg_pwr_i = 5'h0a;
        autorec_en_i = 1'b1;
        remote_ok_i = 1'b0;
        pulse(cfg_apply_i);
        sec(4);
        chk("dflt early", 0, 32'(dflt_act_o));
        sec(1);
        cyc(1);
        chk("dflt", 1, 32'(dflt_act_o));
        chk("odu pwr back", 32'h18, 32'(i_rlem_odu_model.pwr));
        remote_ok_i = 1'b1;
    endtask : t_auto
    task automatic t_lb;
        lb_to_en_i = 1'b1;
        lb_to_sec_i = 8'h02;
        lb_mode_i = RLEM_LB_BB;
        sec(1);
        pulse(lb_apply_i);
        chk("bb on", 2, {30'h0, lb_bb_o, lb_rf_o});
        sec(1);
        chk("bb held", 1, 32'(lb_bb_o));
        sec(1);
        chk("bb expired", 0, 32'(lb_bb_o));
        lb_to_en_i = 1'b0;
        lb_mode_i = RLEM_LB_RF;
        pulse(lb_apply_i);
        sec(3);
        chk("rf held", 1, {30'h0, lb_bb_o, lb_rf_o});
        pulse(lb_clear_i);
        chk("rf cleared", 0, 32'(lb_rf_o));
    endtask : t_lb
    task automatic t_err;
        thr_sel_i = 3'h2;
        thr_val_i = 32'h0006_1a80;
        mon_en_i = 1'b1;
        pulse(thr_wr_i);
        pulse(clr_i);
        sec(1);
        i_rlem_odu_model.send(10, 5);
        sec(1);
        chk("per err/blk", 32'h5000a, {per_err_o[15:0], per_blk_o[15:0]});
        chk("minor major", 3, {30'h0, per_minor_o, per_major_o});
        chk("led fault", 3, {30'h0, rf_err_led_o, per_fault_o});
        chk("es ses bbe", 32'h01_0100, {es_cnt_o[7:0], ses_cnt_o[7:0], bbe_cnt_o[7:0]});
        i_rlem_odu_model.send(10, 1);
        sec(1);
        chk("fault off", 0, 32'(per_fault_o));
        chk("es ses bbe 2", 32'h02_0101, {es_cnt_o[7:0], ses_cnt_o[7:0], bbe_cnt_o[7:0]});
        chk("esr sesr bber", 6, {29'h0, esr_exc_o, sesr_exc_o, bber_exc_o});
        chk("tot av", 32'h0003_0003, {tot_sec_o[15:0], avail_sec_o[15:0]});
        chk("peak", 32'h5000a, {peak_err_o[15:0], peak_blk_o[15:0]});
        chk("eb", 6, eb_cnt_o);
        pulse(clr_i);
        chk("clear", 0, eb_cnt_o | es_cnt_o | ses_cnt_o | bbe_cnt_o | tot_sec_o | peak_err_o);
    endtask : t_err
    task automatic t_avail;
        sec(1);
        repeat (10) begin
            i_rlem_odu_model.send(4, 4);
            sec(1);
        end
        chk("unavail", 1, 32'(link_unavail_o));
        chk("un av", 32'h000a_0001, {unavail_sec_o[15:0], avail_sec_o[15:0]});
        sec(10);
        chk("avail", 0, 32'(link_unavail_o));
        chk("un av 2", 32'h000a_000b, {unavail_sec_o[15:0], avail_sec_o[15:0]});
    endtask : t_avail
    task automatic t_ais;
        frame_unlock_i = 1'b1;
        cyc(4);
        chk("ais", 8'hff, 32'(payload_o));
        frame_unlock_i = 1'b0;
        cyc(4);
        chk("payload", 8'h5a, 32'(payload_o));
    endtask : t_ais
    initial begin
        {lb_apply_i, lb_clear_i, lb_to_en_i, cfg_apply_i, cfg_mute_i, autorec_en_i} = '0;
        {thr_wr_i, mon_en_i, clr_i, frame_unlock_i, lb_to_sec_i, cfg_pwr_i, thr_sel_i} = '0;
        remote_ok_i = 1'b1;
        thr_val_i = '0;
        payload_i = 8'h5a;
        lb_mode_i = RLEM_LB_NONE;
        cfg_plan_i = RLEM_PLAN_A;
        cyc(5);
        srst_i = 1'b0;
        cyc(4);
        chk("boot prog", 1, i_rlem_odu_model.prog_cnt);
        chk("boot pwr", 2, 32'(i_rlem_odu_model.pwr));
        t_cfg();
        t_auto();
        t_lb();
        t_ais();
        t_err();
        t_avail();
        print_verdict();
    end
endmodule : tb_top
